// ---- src/pin_sync2.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pin side
  input wire logic [WIDTH-1:0] async_in,
  // Synchronised side
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // pin_sync2

`default_nettype wire

// ---- src/preset_mode_select.sv ----
// Mode decode, preset defaults and shared-pin steering for the FSK transmitter
//
// Summary of operation
// - Both selects grounded means programming mode
// - Other eight select codes pick preset carrier
// - Clock pin drives 800kHz in preset warm-up and active states, held low in shutdown
// - Presets use 39kHz deviation, Gaussian shaping on
// - Programming mode: clock pin is I2C SCL
// - Programming mode: data pin is I2C SDA
// - Data pin also governs power-up state
// - Presets need no programming, one data wire
// - Data activity during shutdown starts oscillator warm-up
// - Drive boost only for carriers above 850MHz
// - Variants identical in programming mode
// - Presets: data low 4096 internal ticks while active forces shutdown
// - Data high clears the idle counter
// - Presets force maximum PA power code
// - Presets force zero tuning capacitance
`timescale 1ns/1ps
`default_nettype none

package preset_mode_pkg;
  // Tri-level select pin codes
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_VDD = 2'h2;
  localparam int SEL_RADIX = 3;
  localparam int PRESET_COUNT = 9;
  // Frequencies in kHz
  localparam int FREQ_W = 20;
  localparam int SYS_CLK_KHZ = 250000;
  localparam int BUFFERED_CLOCK_OUTPUT_KHZ = 800;
  localparam int INT_OSC_KHZ = 3200;
  localparam int IDLE_TICKS = 4096;
  localparam int IDLE_CYCLES = IDLE_TICKS * (SYS_CLK_KHZ / INT_OSC_KHZ)
                             + (IDLE_TICKS * (SYS_CLK_KHZ % INT_OSC_KHZ)) / INT_OSC_KHZ;
  localparam int WARMUP_US = 243;
  localparam int WARMUP_CYCLES = (WARMUP_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int CAPTURE_CYCLES = 3;
  localparam logic [FREQ_W-1:0] BOOST_MIN_KHZ = 20'hC_F850;
  localparam logic [7:0] PRESET_DEVIATION_KHZ = 8'h27;
  localparam logic [2:0] PRESET_PA_POWER = 3'h7;
  localparam logic [4:0] PRESET_PA_CAP = 5'h00;
  // Carrier tables, index = high code * 3 + low code; entry 0 is programming mode
  localparam logic [FREQ_W-1:0] TABLE_A [PRESET_COUNT] = '{
    20'h0_0000, 20'h4_CE78, 20'hD_FA20, 20'hD_DC84, 20'hD_DE00,
    20'hD_DAE0, 20'hD_F638, 20'h6_9F00, 20'h6_9D0C};
  localparam logic [FREQ_W-1:0] TABLE_B [PRESET_COUNT] = '{
    20'h0_0000, 20'h4_CE78, 20'h6_9F00, 20'hD_4044, 20'hD_4256,
    20'hD_3FCC, 20'hD_45DA, 20'hD_4094, 20'hD_3FFE};
  typedef enum logic [2:0] {
    ST_CAPTURE, ST_PROGRAM, ST_WARMUP, ST_ACTIVE, ST_SHUTDOWN
  } state_t;
endpackage

module preset_mode_select #(
  parameter int VARIANT = 0,
  parameter int SHUTDOWN_CYCLES = preset_mode_pkg::IDLE_CYCLES,
  parameter int WARMUP_LEN = preset_mode_pkg::WARMUP_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // Tri-level select comparators: pin at ground / pin at supply
  input wire logic MODE_SELECT_LOW_GND_IN,
  input wire logic MODE_SELECT_LOW_VDD_IN,
  input wire logic MODE_SELECT_HIGH_GND_IN,
  input wire logic MODE_SELECT_HIGH_VDD_IN,
  // Shared clock pin
  input wire logic CLOCK_PIN_IN,
  output logic BUFFERED_CLOCK_OUTPUT_OUT,
  output logic BUFFERED_CLOCK_OUTPUT_OE_OUT,
  // Shared data pin
  input wire logic DATA_PIN_IN,
  output logic DATA_PIN_OUT,
  output logic DATA_PIN_OE_OUT,
  // Serial programming core
  output logic I2C_SCL_OUT,
  output logic I2C_SDA_OUT,
  input wire logic I2C_SDA_PULL_LOW_IN,
  // Programmed settings
  input wire logic [19:0] REG_CARRIER_KHZ_IN,
  input wire logic [7:0] REG_DEVIATION_KHZ_IN,
  input wire logic REG_GAUSSIAN_EN_IN,
  input wire logic [2:0] REG_PA_POWER_LEVEL_IN,
  input wire logic [4:0] REG_PA_TUNE_CAPACITANCE_IN,
  input wire logic REG_PA_DRIVE_BOOST_IN,
  // Status and transmitter controls
  output logic PROGRAM_MODE_OUT,
  output logic [3:0] PRESET_INDEX_OUT,
  output logic XO_ENABLE_OUT,
  output logic TX_ENABLE_OUT,
  output logic SHUTDOWN_OUT,
  output logic TX_DATA_OUT,
  output logic [19:0] CARRIER_KHZ_OUT,
  output logic [7:0] DEVIATION_KHZ_OUT,
  output logic GAUSSIAN_EN_OUT,
  output logic [2:0] PA_POWER_LEVEL_OUT,
  output logic [4:0] PA_TUNE_CAPACITANCE_OUT,
  output logic PA_DRIVE_BOOST_OUT
);

  localparam int CNT_W = $clog2(SHUTDOWN_CYCLES + WARMUP_LEN + 2);
  localparam int ACC_W = $clog2(preset_mode_pkg::SYS_CLK_KHZ * 2);
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(SHUTDOWN_CYCLES - 1);
  localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARMUP_LEN - 1);
  localparam logic [CNT_W-1:0] CAP_LAST = CNT_W'(preset_mode_pkg::CAPTURE_CYCLES - 1);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * preset_mode_pkg::BUFFERED_CLOCK_OUTPUT_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(preset_mode_pkg::SYS_CLK_KHZ);

  function automatic logic [1:0] level_of(input logic at_gnd, input logic at_vdd);
    if (at_gnd) begin
      level_of = preset_mode_pkg::LVL_GND;
    end else if (at_vdd) begin
      level_of = preset_mode_pkg::LVL_VDD;
    end else begin
      level_of = preset_mode_pkg::LVL_OPEN;
    end
  endfunction

  function automatic logic [19:0] preset_freq(input logic [3:0] idx);
    logic [19:0] f;
    f = 20'h0_0000;
    if (idx < 4'(preset_mode_pkg::PRESET_COUNT)) begin
      f = (VARIANT == 0) ? preset_mode_pkg::TABLE_A[idx] : preset_mode_pkg::TABLE_B[idx];
    end
    preset_freq = f;
  endfunction

  logic [5:0] pins_s;
  logic [1:0] lvl_low;
  logic [1:0] lvl_high;
  logic [3:0] live_idx;
  logic data_s;
  logic scl_s;

  pin_sync2 #(.WIDTH(6)) u_sync (
    .clk_in(SYS_CLK_IN),
    .resetn_in(RESETN_IN),
    .async_in({MODE_SELECT_HIGH_VDD_IN, MODE_SELECT_HIGH_GND_IN, MODE_SELECT_LOW_VDD_IN,
               MODE_SELECT_LOW_GND_IN, CLOCK_PIN_IN, DATA_PIN_IN}),
    .sync_out(pins_s)
  );

  always_comb begin
    data_s = pins_s[0];
    scl_s = pins_s[1];
    lvl_low = level_of(pins_s[2], pins_s[3]);
    lvl_high = level_of(pins_s[4], pins_s[5]);
    live_idx = 4'(lvl_high * 4'(preset_mode_pkg::SEL_RADIX)) + 4'(lvl_low);
  end

  preset_mode_pkg::state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] idx_q, idx_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic clk_q, clk_d;
  logic prog_q, prog_d;

  // Mode capture and power sequencing
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + CNT_W'(1);
    idx_d = idx_q;
    prog_d = prog_q;
    case (state_q)
      preset_mode_pkg::ST_CAPTURE: begin
        // Waits out the synchroniser before trusting the select levels
        if (cnt_q == CAP_LAST) begin
          idx_d = live_idx;
          cnt_d = '0;
          if (live_idx == 4'h0) begin
            prog_d = 1'b1;
            state_d = preset_mode_pkg::ST_PROGRAM;
          end else begin
            prog_d = 1'b0;
            state_d = preset_mode_pkg::ST_WARMUP;
          end
        end
      end
      preset_mode_pkg::ST_PROGRAM: begin
        // Select pins are not rescanned; leaving needs a reset
        cnt_d = cnt_q;
      end
      preset_mode_pkg::ST_WARMUP: begin
        if (cnt_q == WARM_LAST) begin
          cnt_d = '0;
          state_d = preset_mode_pkg::ST_ACTIVE;
        end
      end
      preset_mode_pkg::ST_ACTIVE: begin
        if (data_s) begin
          cnt_d = '0;
        end else if (cnt_q == IDLE_LAST) begin
          cnt_d = '0;
          state_d = preset_mode_pkg::ST_SHUTDOWN;
        end
      end
      preset_mode_pkg::ST_SHUTDOWN: begin
        cnt_d = '0;
        if (data_s) begin
          state_d = preset_mode_pkg::ST_CAPTURE;
        end
      end
      default: begin
        cnt_d = '0;
        state_d = preset_mode_pkg::ST_CAPTURE;
      end
    endcase
  end

  // Fractional divider keeps the average rate exact though 250MHz/800kHz is not whole
  always_comb begin
    acc_d = '0;
    clk_d = 1'b0;
    if (state_q == preset_mode_pkg::ST_WARMUP || state_q == preset_mode_pkg::ST_ACTIVE) begin
      clk_d = clk_q;
      acc_d = acc_q + ACC_STEP;
      if (acc_d >= ACC_WRAP) begin
        acc_d = acc_d - ACC_WRAP;
        clk_d = ~clk_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q <= preset_mode_pkg::ST_CAPTURE;
      cnt_q <= '0;
      idx_q <= 4'h0;
      prog_q <= 1'b0;
      acc_q <= '0;
      clk_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      prog_q <= prog_d;
      acc_q <= acc_d;
      clk_q <= clk_d;
    end
  end

  // Registered outputs
  logic clk_out_d, clk_oe_d, data_out_d, data_oe_d, scl_d, sda_d;
  logic xo_d, tx_d, shdn_d, txdata_d, gauss_d, boost_d;
  logic [19:0] freq_d;
  logic [7:0] dev_d;
  logic [2:0] pwr_d;
  logic [4:0] cap_d;
  // Packed with the pin outputs on top so one flop bank feeds every settings output
  logic [47:0] out_q;
  logic [3:0] idx_out_q;
  logic prog_out_q;

  always_comb begin
    data_out_d = 1'b0;
    clk_out_d = clk_q;
    xo_d = (state_q != preset_mode_pkg::ST_SHUTDOWN);
    tx_d = (state_q == preset_mode_pkg::ST_ACTIVE);
    shdn_d = (state_q == preset_mode_pkg::ST_SHUTDOWN);
    if (prog_q) begin
      clk_oe_d = 1'b0;
      scl_d = scl_s;
      sda_d = data_s;
      data_oe_d = I2C_SDA_PULL_LOW_IN;
      txdata_d = 1'b0;
      // Same path for both variants; the preset table is not consulted
      freq_d = REG_CARRIER_KHZ_IN;
      dev_d = REG_DEVIATION_KHZ_IN;
      gauss_d = REG_GAUSSIAN_EN_IN;
      pwr_d = REG_PA_POWER_LEVEL_IN;
      cap_d = REG_PA_TUNE_CAPACITANCE_IN;
      boost_d = REG_PA_DRIVE_BOOST_IN && (REG_CARRIER_KHZ_IN > preset_mode_pkg::BOOST_MIN_KHZ);
    end else begin
      clk_oe_d = (state_q != preset_mode_pkg::ST_CAPTURE);
      // Programming core sees an idle bus so no register access occurs
      scl_d = 1'b1;
      sda_d = 1'b1;
      data_oe_d = 1'b0;
      txdata_d = data_s && tx_d;
      freq_d = preset_freq(idx_q);
      dev_d = preset_mode_pkg::PRESET_DEVIATION_KHZ;
      gauss_d = 1'b1;
      pwr_d = preset_mode_pkg::PRESET_PA_POWER;
      cap_d = preset_mode_pkg::PRESET_PA_CAP;
      boost_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      out_q <= {4'h0, 1'b1, 2'h0, 2'h3, 3'h0, 20'h0_0000, 8'h00, 3'h0, 5'h00};
      idx_out_q <= 4'h0;
      prog_out_q <= 1'b0;
    end else begin
      out_q <= {clk_out_d, clk_oe_d, data_out_d, data_oe_d, xo_d, tx_d, shdn_d, scl_d, sda_d,
                gauss_d, txdata_d, boost_d, freq_d, dev_d, pwr_d, cap_d};
      idx_out_q <= idx_q;
      prog_out_q <= prog_q;
    end
  end

  assign BUFFERED_CLOCK_OUTPUT_OUT = out_q[47];
  assign BUFFERED_CLOCK_OUTPUT_OE_OUT = out_q[46];
  assign DATA_PIN_OUT = out_q[45];
  assign DATA_PIN_OE_OUT = out_q[44];
  assign XO_ENABLE_OUT = out_q[43];
  assign TX_ENABLE_OUT = out_q[42];
  assign SHUTDOWN_OUT = out_q[41];
  assign I2C_SCL_OUT = out_q[40];
  assign I2C_SDA_OUT = out_q[39];
  assign GAUSSIAN_EN_OUT = out_q[38];
  assign TX_DATA_OUT = out_q[37];
  assign PA_DRIVE_BOOST_OUT = out_q[36];
  assign CARRIER_KHZ_OUT = out_q[35:16];
  assign DEVIATION_KHZ_OUT = out_q[15:8];
  assign PA_POWER_LEVEL_OUT = out_q[7:5];
  assign PA_TUNE_CAPACITANCE_OUT = out_q[4:0];
  assign PRESET_INDEX_OUT = idx_out_q;
  assign PROGRAM_MODE_OUT = prog_out_q;

endmodule // preset_mode_select

`default_nettype wire

// ---- verif/mcu_model.sv ----
// Microcontroller side model: select straps, data wire and I2C clock
`timescale 1ns/1ps
`default_nettype none

module mcu_model (
  // Bench commands
  input wire logic [1:0] sel_hi_in,
  input wire logic [1:0] sel_lo_in,
  input wire logic data_in,
  input wire logic scl_in,
  // Device pin drivers
  input wire logic dut_clk_in,
  input wire logic dut_clk_oe_in,
  input wire logic dut_sda_oe_in,
  // Resolved pin levels
  output logic lo_gnd_out,
  output logic lo_vdd_out,
  output logic hi_gnd_out,
  output logic hi_vdd_out,
  output logic clock_pin_out,
  output logic data_pin_out
);
  // Straps are static wiring; open reads as neither comparator
  assign lo_gnd_out = (sel_lo_in == 2'h0);
  assign lo_vdd_out = (sel_lo_in == 2'h2);
  assign hi_gnd_out = (sel_hi_in == 2'h0);
  assign hi_vdd_out = (sel_hi_in == 2'h2);
  // Device wins the clock pin while it drives it
  assign clock_pin_out = dut_clk_oe_in ? dut_clk_in : scl_in;
  // Open drain with pull-up: either side can pull low
  assign data_pin_out = data_in && !dut_sda_oe_in;
endmodule // mcu_model

`default_nettype wire

// ---- verif/mode_select_sva.sv ----
// Port checker for the mode select block
`timescale 1ns/1ps
`default_nettype none

module mode_select_sva #(
  parameter int SHUTDOWN_CYCLES = 64
) (
  input wire logic SYS_CLK_IN, RESETN_IN, DATA_PIN_IN,
  input wire logic PROGRAM_MODE_OUT, TX_ENABLE_OUT, SHUTDOWN_OUT, XO_ENABLE_OUT,
  input wire logic BUFFERED_CLOCK_OUTPUT_OE_OUT, GAUSSIAN_EN_OUT, PA_DRIVE_BOOST_OUT,
  input wire logic [3:0] PRESET_INDEX_OUT,
  input wire logic [19:0] CARRIER_KHZ_OUT,
  input wire logic [7:0] DEVIATION_KHZ_OUT,
  input wire logic [2:0] PA_POWER_LEVEL_OUT,
  input wire logic [4:0] PA_TUNE_CAPACITANCE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  int idle_q;
  int idle_d;
  logic run;
  assign run = TX_ENABLE_OUT && !PROGRAM_MODE_OUT;
  // Raw pin leads the synchroniser, so this count is never short
  always_comb idle_d = DATA_PIN_IN ? 0 : idle_q + 1;
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) idle_q <= 0;
    else idle_q <= idle_d;
  end
  sequence s_wake;
    SHUTDOWN_OUT ##1 DATA_PIN_IN [*3];
  endsequence
  a_prog_no_clk: assert property (
    PROGRAM_MODE_OUT |-> !BUFFERED_CLOCK_OUTPUT_OE_OUT) else $error("clock pin driven");
  a_preset_clk: assert property (
    run |-> BUFFERED_CLOCK_OUTPUT_OE_OUT) else $error("clock pin idle in preset");
  a_preset_mod: assert property (
    run |-> DEVIATION_KHZ_OUT == 8'h27 && GAUSSIAN_EN_OUT) else $error("preset modulation");
  a_preset_pa: assert property (
    run |-> PA_POWER_LEVEL_OUT == 3'h7 && PA_TUNE_CAPACITANCE_OUT == 5'h00)
    else $error("preset PA setting");
  a_boost_band: assert property (
    PA_DRIVE_BOOST_OUT |-> CARRIER_KHZ_OUT > 20'hC_F850) else $error("boost below band");
  a_prog_sticky: assert property (
    PROGRAM_MODE_OUT |=> PROGRAM_MODE_OUT) else $error("programming mode dropped");
  a_index_hold: assert property (
    run && $past(run) |-> $stable(PRESET_INDEX_OUT)) else $error("index moved");
  a_wake_xo: assert property (
    s_wake |-> ##[0:8] XO_ENABLE_OUT) else $error("no warm-up on data activity");
  a_shut_idle: assert property (
    $rose(SHUTDOWN_OUT) |-> idle_q >= SHUTDOWN_CYCLES) else $error("early shutdown");
endmodule // mode_select_sva

bind preset_mode_select mode_select_sva #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) u_sva (
  .SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN), .DATA_PIN_IN(DATA_PIN_IN),
  .PROGRAM_MODE_OUT(PROGRAM_MODE_OUT), .TX_ENABLE_OUT(TX_ENABLE_OUT),
  .SHUTDOWN_OUT(SHUTDOWN_OUT), .XO_ENABLE_OUT(XO_ENABLE_OUT),
  .BUFFERED_CLOCK_OUTPUT_OE_OUT(BUFFERED_CLOCK_OUTPUT_OE_OUT),
  .GAUSSIAN_EN_OUT(GAUSSIAN_EN_OUT), .PA_DRIVE_BOOST_OUT(PA_DRIVE_BOOST_OUT),
  .PRESET_INDEX_OUT(PRESET_INDEX_OUT), .CARRIER_KHZ_OUT(CARRIER_KHZ_OUT),
  .DEVIATION_KHZ_OUT(DEVIATION_KHZ_OUT), .PA_POWER_LEVEL_OUT(PA_POWER_LEVEL_OUT),
  .PA_TUNE_CAPACITANCE_OUT(PA_TUNE_CAPACITANCE_OUT));

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the mode select block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int SHUT = 64;
  localparam int WARM = 16;
  logic clk, rstn, dat, scl, sda_pull, gau, bst, lg, lv, hg, hv, cpin, dpin;
  logic ck, ckoe, doe, scl_o, sda_o, pm, xo, txe, shd, txd, gau_o, bo, dout;
  logic [1:0] shi, slo;
  logic [3:0] idx;
  logic [19:0] rcar, car;
  logic [7:0] rdev, dev;
  logic [2:0] rpwr, pwr;
  logic [4:0] rcap, cap;
  logic [31:0] seed = 32'h0000_01D3;
  int bad_count = 0;
  int tests_run = 0;
  int e, pk;
  int ftab [9] = '{0, 315000, 916000, 908420, 908800, 908000, 915000, 433920, 433420};

  mcu_model u_mcu (.sel_hi_in(shi), .sel_lo_in(slo), .data_in(dat), .scl_in(scl),
    .dut_clk_in(ck), .dut_clk_oe_in(ckoe), .dut_sda_oe_in(doe), .lo_gnd_out(lg),
    .lo_vdd_out(lv), .hi_gnd_out(hg), .hi_vdd_out(hv), .clock_pin_out(cpin),
    .data_pin_out(dpin));
  preset_mode_select #(.VARIANT(0), .SHUTDOWN_CYCLES(SHUT), .WARMUP_LEN(WARM)) DUT (
    .SYS_CLK_IN(clk), .RESETN_IN(rstn), .MODE_SELECT_LOW_GND_IN(lg),
    .MODE_SELECT_LOW_VDD_IN(lv), .MODE_SELECT_HIGH_GND_IN(hg), .MODE_SELECT_HIGH_VDD_IN(hv),
    .CLOCK_PIN_IN(cpin), .BUFFERED_CLOCK_OUTPUT_OUT(ck), .BUFFERED_CLOCK_OUTPUT_OE_OUT(ckoe),
    .DATA_PIN_IN(dpin), .DATA_PIN_OUT(dout), .DATA_PIN_OE_OUT(doe), .I2C_SCL_OUT(scl_o),
    .I2C_SDA_OUT(sda_o), .I2C_SDA_PULL_LOW_IN(sda_pull), .REG_CARRIER_KHZ_IN(rcar),
    .REG_DEVIATION_KHZ_IN(rdev), .REG_GAUSSIAN_EN_IN(gau), .REG_PA_POWER_LEVEL_IN(rpwr),
    .REG_PA_TUNE_CAPACITANCE_IN(rcap), .REG_PA_DRIVE_BOOST_IN(bst), .PROGRAM_MODE_OUT(pm),
    .PRESET_INDEX_OUT(idx), .XO_ENABLE_OUT(xo), .TX_ENABLE_OUT(txe), .SHUTDOWN_OUT(shd),
    .TX_DATA_OUT(txd), .CARRIER_KHZ_OUT(car), .DEVIATION_KHZ_OUT(dev),
    .GAUSSIAN_EN_OUT(gau_o), .PA_POWER_LEVEL_OUT(pwr), .PA_TUNE_CAPACITANCE_OUT(cap),
    .PA_DRIVE_BOOST_OUT(bo));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [19:0] x, input logic [19:0] g);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic boot(input int h, input int l);
    shi = 2'(h);
    slo = 2'(l);
    // Data held high so the idle timer cannot run during boot
    {dat, scl, rstn} = 3'h6;
    {rcar, rdev, rpwr, rcap, gau, bst, sda_pull} = 39'(rnd() * rnd());
    cyc(12);
    rstn = 1;
    cyc(10 + WARM);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    bad_count++;
    stop_test();
  end
  initial begin
    boot(0, 0);
    for (int c = 0; c < 9; c++) begin
      boot(c / 3, c % 3);
      chk("mode", 20'(c == 0), pm);
      chk("index", 20'(c), idx);
      chk("data_out", 0, dout);
      if (c == 0) begin
        chk("carrier", rcar, car);
        chk("deviation", rdev, dev);
        chk("boost", bst && rcar > 850000, bo);
        chk("clk_oe", 0, ckoe);
        sda_pull = 0;
        for (int v = 0; v < 2; v++) begin
          scl = v[0];
          dat = v[0];
          cyc(4);
          chk("scl", v, scl_o);
          chk("sda", v, sda_o);
        end
        dat = 1;
      end else begin
        chk("carrier", ftab[c], car);
        chk("deviation", 39, dev);
        chk("gauss", 1, gau_o);
        chk("power", 7, pwr);
        chk("cap", 0, cap);
        chk("boost", 0, bo);
        chk("clk_oe", 1, ckoe);
        chk("tx_en", 1, txe);
      end
      $display("test select %0d done", c);
    end
    // 3125 cycles at 250 MHz span ten periods of 800 kHz; allow phase slack
    e = 0;
    pk = 0;
    repeat (3125) begin
      @(negedge clk);
      if (ck && pk == 0) e++;
      pk = ck;
    end
    chk("clk_edges", 10, (e >= 9 && e <= 11) ? 10 : e);
    shi = 2'h0;
    cyc(10);
    chk("index_hold", 8, idx);
    dat = 0;
    cyc(SHUT - 20);
    dat = 1;
    cyc(2);
    dat = 0;
    cyc(SHUT - 20);
    chk("no_shut", 0, shd);
    cyc(40);
    chk("shut", 1, shd);
    dat = 1;
    cyc(8);
    chk("xo", 1, xo);
    cyc(10 + WARM);
    chk("index_new", 2, idx);
    chk("carrier", ftab[2], car);
    for (int v = 0; v < 2; v++) begin
      dat = v[0];
      cyc(4);
      chk("tx_data", v, txd);
    end
    $display("test shutdown and wake done");
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
